/* File: src/sms_link_if.sv */
// serial link between the port and its peer, with pin resolution
`timescale 1ns/1ps
`default_nettype none
interface sms_link_if;
   logic dev_sck_o,  dev_sck_oe,  peer_sck_o,  peer_sck_oe;
   logic dev_mosi_o, dev_mosi_oe, peer_mosi_o, peer_mosi_oe;
   logic dev_miso_o, dev_miso_oe, peer_miso_o, peer_miso_oe;
   logic dev_ssn_o,  dev_ssn_oe,  peer_ssn_o,  peer_ssn_oe;
   logic sck;
   logic mosi;
   logic miso;
   logic slave_select_pin;

   // undriven lines float high through the pull-up
   assign sck  = (dev_sck_oe ? dev_sck_o : 1'b1) & (peer_sck_oe ? peer_sck_o : 1'b1);
   assign mosi = (dev_mosi_oe ? dev_mosi_o : 1'b1) & (peer_mosi_oe ? peer_mosi_o : 1'b1);
   assign miso = (dev_miso_oe ? dev_miso_o : 1'b1) & (peer_miso_oe ? peer_miso_o : 1'b1);
   assign slave_select_pin  = (dev_ssn_oe ? dev_ssn_o : 1'b1) & (peer_ssn_oe ? peer_ssn_o : 1'b1);

   modport dev (
      output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
      output dev_miso_o, dev_miso_oe, dev_ssn_o, dev_ssn_oe,
      input  sck, mosi, miso, slave_select_pin
   );
   modport peer (
      output peer_sck_o, peer_sck_oe, peer_mosi_o, peer_mosi_oe,
      output peer_miso_o, peer_miso_oe, peer_ssn_o, peer_ssn_oe,
      input  sck, mosi, miso, slave_select_pin
   );
endinterface
`default_nettype wire

/* File: src/sms_peer.sv */
// far end of the link: a plain serial master or slave with a user port
`timescale 1ns/1ps
`default_nettype none
module sms_peer #(
   parameter int HALF_CYCLES = 4
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   sms_link_if.peer        link,
   input  wire logic       master_mode,
   input  wire logic       clock_polarity,
   input  wire logic       clock_phase,
   input  wire logic       start,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte,
   output logic            done,
   output logic            busy
);
   import sms_pkg::*;

   typedef struct packed {
      sms_state_t st;
      logic [3:0] edges;
      logic [6:0] div;
      logic       sck_lvl;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] rx_byte;
      logic       done;
      logic       busy;
      logic       sck_prev;
      logic       ssn_prev;
   } sms_peer_state_t;

   localparam logic [6:0] HALF_LAST = 7'(HALF_CYCLES - 1);

   sms_peer_state_t s;
   sms_peer_state_t next_s;
   logic [2:0]      pins_s;
   logic            step;
   logic            din;

   sms_sync #(.W(3), .INIT(3'b001)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({link.sck, link.mosi, link.slave_select_pin}),
      .q     (pins_s)
   );

   always_comb begin
      next_s          = s;
      next_s.done     = 1'b0;
      next_s.sck_prev = pins_s[2];
      next_s.ssn_prev = pins_s[0];
      step            = 1'b0;
      din             = master_mode ? link.miso : pins_s[1];
      if (master_mode) begin
         unique case (s.st)
            SMS_IDLE: begin
               next_s.sck_lvl = clock_polarity;
               if (start) begin
                  next_s.st    = SMS_RUN;
                  next_s.tx    = tx_byte;
                  next_s.div   = DIV_ZERO;
                  next_s.edges = EDGE_FIRST;
               end
            end
            SMS_RUN, SMS_TAIL: begin
               if (s.div == HALF_LAST) begin
                  next_s.div = DIV_ZERO;
                  if (s.st == SMS_RUN) begin
                     next_s.sck_lvl = !s.sck_lvl;
                     step           = 1'b1;
                  end else begin
                     next_s.st = SMS_IDLE;
                  end
               end else begin
                  next_s.div = s.div + DIV_ONE;
               end
            end
            default: next_s.st = SMS_IDLE;
         endcase
      end else begin
         next_s.st      = SMS_IDLE;
         next_s.sck_lvl = clock_polarity;
         if (start && s.edges == EDGE_FIRST) begin
            next_s.tx = tx_byte;
         end
         step = !pins_s[0] && (pins_s[2] != s.sck_prev);
      end
      if (step) begin
         if (s.edges[0] == clock_phase) begin
            next_s.rx = {s.rx[6:0], din};
         end else if (!(clock_phase && s.edges == EDGE_FIRST)) begin
            next_s.tx = {s.tx[6:0], 1'b0};
         end
         next_s.edges = s.edges + 4'h1;
         if (s.edges == EDGE_LAST) begin
            next_s.rx_byte = next_s.rx;
            next_s.done    = 1'b1;
            if (master_mode) begin
               next_s.st = SMS_TAIL;
            end
         end
      end
      // a slave select that rises mid-byte drops the partial word
      if (!master_mode && pins_s[0] && !s.ssn_prev) begin
         next_s.edges = EDGE_FIRST;
      end
      next_s.busy = master_mode ? (next_s.st != SMS_IDLE) : (next_s.edges != EDGE_FIRST);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s          <= '0;
         s.ssn_prev <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rx_byte           = s.rx_byte;
   assign done              = s.done;
   assign busy              = s.busy;
   assign link.peer_sck_o   = s.sck_lvl;
   assign link.peer_sck_oe  = master_mode;
   assign link.peer_mosi_o  = s.tx[7];
   assign link.peer_mosi_oe = master_mode;
   assign link.peer_ssn_o   = (s.st == SMS_IDLE);
   assign link.peer_ssn_oe  = master_mode;
   assign link.peer_miso_o  = s.tx[7];
   assign link.peer_miso_oe = !master_mode && !s.ssn_prev;
endmodule
`default_nettype wire

/* File: src/sms_pkg.sv */
// shared constants and types for the serial master/slave port and its peer
package sms_pkg;
   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int           APB_AW     = 12;
   localparam int           APB_DW     = 32;
   localparam int           IDX_LSB    = 2;
   localparam int           IDX_MSB    = 9;
   localparam logic [7:0]   BYTE_ZERO  = 8'h00;
   localparam logic [23:0]  RDATA_PAD  = 24'h000000;

   // ---------------------------------------------------------------
   // register indices (byte address is index times four)
   // ---------------------------------------------------------------
   localparam logic [7:0]   IDX_IRQ_LOW   = 8'hA8;
   localparam logic [7:0]   IDX_IRQ_HIGH  = 8'hB8;
   localparam logic [7:0]   IDX_STATUS    = 8'hE1;
   localparam logic [7:0]   IDX_CONTROL   = 8'hE2;
   localparam logic [7:0]   IDX_DATA      = 8'hE3;
   localparam logic [7:0]   IDX_P1_OD     = 8'hE4;
   localparam logic [7:0]   IDX_P0_DIR    = 8'hF9;
   localparam logic [7:0]   IDX_P1_DIR    = 8'hFA;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTL_SPR2  = 7;
   localparam int CTL_EN    = 6;
   localparam int CTL_SLAVE_SELECT_DISABLE = 5;
   localparam int CTL_MASTER_SELECT  = 4;
   localparam int CTL_CLOCK_POLARITY  = 3;
   localparam int CTL_CLOCK_PHASE  = 2;
   localparam int CTL_SPR1  = 1;
   localparam int CTL_SPR0  = 0;
   localparam int STA_DONE  = 7;
   localparam int STA_WRITE_COLLISION_FLAG  = 6;
   localparam int STA_SELECT_ERROR_FLAG = 5;
   localparam int STA_MODE_FAULT_FLAG  = 4;
   localparam int IRQ_ENABLE_LOW_GLB  = 7;
   localparam int IRQ_ENABLE_HIGH_PORT = 1;
   localparam int OD_SCK    = 2;
   localparam int OD_MISO   = 1;
   localparam int OD_MOSI   = 0;
   localparam int DIR_SSN   = 7;
   localparam int DIR_SCK   = 3;
   localparam int DIR_MISO  = 2;
   localparam int DIR_MOSI  = 1;

   // ---------------------------------------------------------------
   // writable masks and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]   MASK_IRQ_LOW  = 8'h80;
   localparam logic [7:0]   MASK_IRQ_HIGH = 8'h02;
   localparam logic [7:0]   MASK_P1_OD    = 8'h07;
   localparam logic [7:0]   MASK_P0_DIR   = 8'h80;
   localparam logic [7:0]   MASK_P1_DIR   = 8'h0E;
   localparam logic [7:0]   CTL_RST       = 8'h14;

   // ---------------------------------------------------------------
   // framing
   // ---------------------------------------------------------------
   localparam logic [3:0]   EDGE_FIRST = 4'h0;
   localparam logic [3:0]   EDGE_LAST  = 4'hF;
   localparam logic [2:0]   SPR_MAX    = 3'h6;
   localparam logic [6:0]   DIV_ONE    = 7'h01;
   localparam logic [6:0]   DIV_ZERO   = 7'h00;

   typedef enum logic [1:0] {
      SMS_IDLE = 2'b00,
      SMS_RUN  = 2'b01,
      SMS_TAIL = 2'b10
   } sms_state_t;
endpackage

/* File: src/sms_port.sv */
// serial master/slave port with its register file on APB
`timescale 1ns/1ps
`default_nettype none
module sms_port (
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [sms_pkg::APB_AW-1:0]   paddr,
   input  wire logic [sms_pkg::APB_DW-1:0]   pwdata,
   output logic      [sms_pkg::APB_DW-1:0]   prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              port_irq,
   sms_link_if.dev                           link
);
   import sms_pkg::*;

   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  irq_enable_low;
      logic [7:0]  irq_enable_high;
      logic [7:0]  od;
      logic [7:0]  p0dir;
      logic [7:0]  p1dir;
      logic        transfer_done_flag;
      logic        write_collision_flag;
      logic        select_error_flag;
      logic        mode_fault_flag;
      logic        armed;
      sms_state_t  st;
      logic [3:0]  edges;
      logic [6:0]  div;
      logic        sck_lvl;
      logic [7:0]  tx;
      logic [7:0]  rx;
      logic [7:0]  data;
      logic        sck_prev;
      logic        ssn_prev;
      logic        ssn_seen_high;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        irq;
   } sms_port_state_t;

   sms_port_state_t s;
   sms_port_state_t next_s;
   logic [3:0]      pins_s;
   logic            sck_s, miso_s, mosi_s, ssn_s;
   logic [2:0]      spr;
   logic [6:0]      half;
   logic            en, master_select, clock_polarity, clock_phase, slave_select_disable, ss_used, busy;
   logic            acc, wr, rd, mapped, step, din;
   logic [7:0]      idx, rd8;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   sms_sync #(.W(4), .INIT(4'b0001)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({link.sck, link.miso, link.mosi, link.slave_select_pin}),
      .q     (pins_s)
   );
   assign {sck_s, miso_s, mosi_s, ssn_s} = pins_s;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      en     = s.ctl[CTL_EN];
      master_select   = s.ctl[CTL_MASTER_SELECT];
      clock_polarity   = s.ctl[CTL_CLOCK_POLARITY];
      clock_phase   = s.ctl[CTL_CLOCK_PHASE];
      slave_select_disable  = s.ctl[CTL_SLAVE_SELECT_DISABLE];
      spr    = {s.ctl[CTL_SPR2], s.ctl[CTL_SPR1], s.ctl[CTL_SPR0]};
      // reserved rate code runs at the slowest rate
      if (spr > SPR_MAX) begin
         spr = SPR_MAX;
      end
      half    = DIV_ONE << spr;
      ss_used = !(slave_select_disable && !clock_phase);
      busy    = master_select ? (s.st != SMS_IDLE) : (s.edges != EDGE_FIRST);
      idx     = paddr[IDX_MSB:IDX_LSB];
      acc     = psel && penable && s.pready;
      wr      = acc && pwrite;
      rd      = acc && !pwrite;
      step    = 1'b0;
      din     = master_select ? miso_s : mosi_s;

      // register decode; answer is ready one cycle after setup
      mapped = (paddr[APB_AW-1:IDX_MSB+1] == '0);
      unique case (idx)
         IDX_IRQ_LOW:  rd8 = s.irq_enable_low;
         IDX_IRQ_HIGH: rd8 = s.irq_enable_high;
         IDX_STATUS:   rd8 = {s.transfer_done_flag, s.write_collision_flag, s.select_error_flag, s.mode_fault_flag, 4'h0};
         IDX_CONTROL:  rd8 = s.ctl;
         IDX_DATA:     rd8 = s.data;
         IDX_P1_OD:    rd8 = s.od;
         IDX_P0_DIR:   rd8 = s.p0dir;
         IDX_P1_DIR:   rd8 = s.p1dir;
         default: begin
            rd8    = BYTE_ZERO;
            mapped = 1'b0;
         end
      endcase
      next_s.pready  = psel && !penable;
      next_s.pslverr = psel && !penable && !mapped;
      next_s.prdata  = (psel && !penable && mapped) ? {RDATA_PAD, rd8} : '0;

      // software side effects first, so hardware sets below win
      if (wr && mapped) begin
         unique case (idx)
            IDX_CONTROL:  next_s.ctl   = pwdata[7:0];
            IDX_IRQ_LOW:  next_s.irq_enable_low  = pwdata[7:0] & MASK_IRQ_LOW;
            IDX_IRQ_HIGH: next_s.irq_enable_high  = pwdata[7:0] & MASK_IRQ_HIGH;
            IDX_P1_OD:    next_s.od    = pwdata[7:0] & MASK_P1_OD;
            IDX_P0_DIR:   next_s.p0dir = pwdata[7:0] & MASK_P0_DIR;
            IDX_P1_DIR:   next_s.p1dir = pwdata[7:0] & MASK_P1_DIR;
            IDX_DATA: begin
               if (busy) begin
                  next_s.write_collision_flag = 1'b1;
               end else begin
                  next_s.tx = pwdata[7:0];
                  if (master_select && en) begin
                     next_s.st    = SMS_RUN;
                     next_s.div   = DIV_ZERO;
                     next_s.edges = EDGE_FIRST;
                  end
               end
            end
            default: next_s.ctl = s.ctl;
         endcase
      end
      if (rd && mapped && idx == IDX_STATUS) begin
         next_s.armed = 1'b1;
      end
      if (rd && mapped && idx == IDX_DATA && s.armed) begin
         next_s.transfer_done_flag  = 1'b0;
         next_s.write_collision_flag  = 1'b0;
         next_s.mode_fault_flag  = 1'b0;
         next_s.armed = 1'b0;
      end

      // serial engine
      next_s.sck_prev = sck_s;
      next_s.ssn_prev = ssn_s;
      if (ssn_s) begin
         next_s.ssn_seen_high = 1'b1;
      end
      if (master_select) begin
         if (s.st == SMS_IDLE) begin
            next_s.sck_lvl = clock_polarity;
         end else if (s.div == half - DIV_ONE) begin
            next_s.div = DIV_ZERO;
            if (s.st == SMS_RUN) begin
               next_s.sck_lvl = !s.sck_lvl;
               step           = 1'b1;
            end else begin
               next_s.st = SMS_IDLE;
            end
         end else begin
            next_s.div = s.div + DIV_ONE;
         end
      end else begin
         next_s.sck_lvl = clock_polarity;
         step = en && (sck_s != s.sck_prev) && (!ss_used || !ssn_s);
      end
      if (step) begin
         if (s.edges[0] == clock_phase) begin
            next_s.rx = {s.rx[6:0], din};
         end else if (!(clock_phase && s.edges == EDGE_FIRST)) begin
            next_s.tx = {s.tx[6:0], 1'b0};
         end
         // phase zero slaves need SLAVE_SELECT_PIN high between bytes unless slave select is disabled
         if (!master_select && ss_used && !clock_phase && s.edges == EDGE_FIRST && !s.ssn_seen_high) begin
            next_s.select_error_flag = 1'b1;
         end
         next_s.edges = s.edges + 4'h1;
         if (s.edges == EDGE_LAST) begin
            next_s.data          = next_s.rx;
            next_s.transfer_done_flag          = 1'b1;
            next_s.ssn_seen_high = ssn_s;
            if (master_select) begin
               next_s.st = SMS_TAIL;
            end
         end
      end
      if (!master_select && ss_used && ssn_s && !s.ssn_prev && s.edges != EDGE_FIRST) begin
         next_s.mode_fault_flag  = 1'b1;
         next_s.edges = EDGE_FIRST;
      end
      // master sees SLAVE_SELECT_PIN pulled low by another master
      if (master_select && s.st == SMS_RUN && !slave_select_disable && !s.p0dir[DIR_SSN] && !ssn_s) begin
         next_s.mode_fault_flag  = 1'b1;
         next_s.st    = SMS_IDLE;
         next_s.edges = EDGE_FIRST;
      end
      if (!en) begin
         next_s.st    = SMS_IDLE;
         next_s.edges = EDGE_FIRST;
         next_s.select_error_flag = 1'b0;
      end
      next_s.irq = next_s.irq_enable_low[IRQ_ENABLE_LOW_GLB] && next_s.irq_enable_high[IRQ_ENABLE_HIGH_PORT]
                   && (next_s.transfer_done_flag || next_s.mode_fault_flag);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s               <= '0;
         s.ctl           <= CTL_RST;
         s.sck_lvl       <= CTL_RST[CTL_CLOCK_POLARITY];
         s.ssn_prev      <= 1'b1;
         s.ssn_seen_high <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata   = s.prdata;
   assign pready   = s.pready;
   assign pslverr  = s.pslverr;
   assign port_irq = s.irq;

   // open-drain pins drive only a low level
   assign link.dev_sck_o   = s.sck_lvl;
   assign link.dev_sck_oe  = s.p1dir[DIR_SCK] && !(s.od[OD_SCK] && s.sck_lvl);
   assign link.dev_mosi_o  = s.tx[7];
   assign link.dev_mosi_oe = s.p1dir[DIR_MOSI] && !(s.od[OD_MOSI] && s.tx[7]);
   assign link.dev_miso_o  = s.tx[7];
   assign link.dev_miso_oe = s.p1dir[DIR_MISO] && !(s.od[OD_MISO] && s.tx[7]);
   assign link.dev_ssn_o   = (s.st == SMS_IDLE);
   assign link.dev_ssn_oe  = s.p0dir[DIR_SSN];
endmodule
`default_nettype wire

/* File: src/sms_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sms_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] f1;
      logic [W-1:0] f2;
      logic [W-1:0] f3;
      logic [W-1:0] q;
   } sms_sync_state_t;

   sms_sync_state_t s;
   sms_sync_state_t next_s;

   always_comb begin
      next_s    = s;
      next_s.f1 = d;
      next_s.f2 = s.f1;
      next_s.f3 = s.f2;
      // a change counts only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (s.f2[i] == s.f3[i]) begin
            next_s.q[i] = s.f3[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s <= {INIT, INIT, INIT, INIT};
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;
endmodule
`default_nettype wire

/* File: tb/sms_link_properties.sv */
// link-level properties for the serial port facing its peer
`timescale 1ns/1ps
`default_nettype none
module sms_link_properties (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe,
   input wire logic dev_ssn_o,
   input wire logic peer_sck_o,
   input wire logic peer_ssn_o,
   input wire logic peer_miso_oe,
   input wire logic slave_select_pin
);
   logic [5:0] dev_cnt;
   logic [5:0] peer_cnt;
   logic       dev_prev;
   logic       peer_prev;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // --------
   // clock edges seen in a frame, cleared while deselected
   // --------
   always_ff @(posedge clock) begin
      dev_prev  <= dev_sck_o;
      peer_prev <= peer_sck_o;
      dev_cnt   <= dev_ssn_o ? 6'h00 : dev_cnt + 6'(dev_sck_o != dev_prev);
      peer_cnt  <= peer_ssn_o ? 6'h00 : peer_cnt + 6'(peer_sck_o != peer_prev);
   end
   property p_dev_start;
      $fell(dev_ssn_o) && dev_sck_oe |-> $stable(dev_sck_o)[*2];
   endproperty
   a_dev_start: assert property (p_dev_start) else $error("sck moved as frame opened");
   property p_dev_len;
      $rose(dev_ssn_o) && dev_sck_oe |-> dev_cnt == 6'h10;
   endproperty
   a_dev_len: assert property (p_dev_len) else $error("master frame edge count");
   property p_dev_idle;
      $rose(dev_ssn_o) && dev_sck_oe |-> $stable(dev_sck_o)[*3];
   endproperty
   a_dev_idle: assert property (p_dev_idle) else $error("sck not idle after frame");
   property p_dev_bound;
      $fell(dev_ssn_o) && dev_sck_oe |-> ##[60:600] $rose(dev_ssn_o);
   endproperty
   a_dev_bound: assert property (p_dev_bound) else $error("master frame length");
   property p_peer_len;
      $rose(peer_ssn_o) |-> peer_cnt == 6'h10;
   endproperty
   a_peer_len: assert property (p_peer_len) else $error("peer frame edge count");
   property p_peer_start;
      $fell(peer_ssn_o) |-> $stable(peer_sck_o)[*3];
   endproperty
   a_peer_start: assert property (p_peer_start) else $error("peer sck moved early");
   property p_peer_bound;
      $fell(peer_ssn_o) |-> ##[130:140] $rose(peer_ssn_o);
   endproperty
   a_peer_bound: assert property (p_peer_bound) else $error("peer frame length");
   property p_peer_release;
      // the peer releases miso one clock after its synchronised select goes high
      slave_select_pin[*6] |-> !peer_miso_oe;
   endproperty
   a_peer_release: assert property (p_peer_release) else $error("miso held when idle");
   c_dev_frame: cover property ($rose(dev_ssn_o) && dev_sck_oe);
   c_peer_frame: cover property ($rose(peer_ssn_o));
   c_idle_select: cover property (slave_select_pin[*5]);
endmodule
`default_nettype wire

/* File: tb/sms_port_tb.sv */
// self-checking bench: port and peer joined over the link
`timescale 1ns/1ps
`default_nettype none
module sms_port_tb;
   import sms_pkg::*;
   logic        clock, rst_n, p_rst_n, psel, penable, pwrite, pready, pslverr, port_irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        p_mst, p_pol, p_pha, p_start, p_done, p_busy;
   logic [7:0]  p_tx, p_rx;
   int          err_count, cmp_count, i;
   sms_link_if lnk ();
   sms_port i_sms_port (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .port_irq, .link(lnk.dev));
   // peer sck half period must cover the port's pin synchroniser round trip
   sms_peer #(.HALF_CYCLES(8)) i_sms_peer (.clock, .rst_n(p_rst_n), .link(lnk.peer),
      .master_mode(p_mst), .clock_polarity(p_pol), .clock_phase(p_pha), .start(p_start), .tx_byte(p_tx),
      .rx_byte(p_rx), .done(p_done), .busy(p_busy));
   sms_link_properties i_props (.clock, .rst_n(rst_n && p_rst_n), .dev_sck_o(lnk.dev_sck_o),
      .dev_sck_oe(lnk.dev_sck_oe), .dev_ssn_o(lnk.dev_ssn_o), .peer_sck_o(lnk.peer_sck_o),
      .peer_ssn_o(lnk.peer_ssn_o), .peer_miso_oe(lnk.peer_miso_oe), .slave_select_pin(lnk.slave_select_pin));
   // --------
   // bus and compare helpers
   // --------
   function automatic logic [11:0] ad(input logic [7:0] x);
      return {2'b00, x, 2'b00};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      // pready, prdata and pslverr are read as they stand at the rising edge
      do @(posedge clock); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string n, input logic [7:0] x, input logic [7:0] e);
      apb(1'b0, ad(x), 8'h00);
      chk(n, {24'h000000, e}, rd);
   endtask
   task automatic pgo(input logic [7:0] t);
      @(posedge clock);
      p_tx    <= t;
      p_start <= 1'b1;
      @(posedge clock);
      p_start <= 1'b0;
   endtask
   task automatic wait_end;
      for (i = 0; i < 3000 && p_done !== 1'b1; i++) @(negedge clock);
      chk("peer_done", 32'h1, {31'h0, p_done});
      rd = '0;
      for (i = 0; i < 40 && rd[7] !== 1'b1; i++) apb(1'b0, ad(IDX_STATUS), 8'h00);
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_master(input logic [1:0] m);
      p_mst <= 1'b0;
      p_pol <= m[1];
      p_pha <= m[0];
      apb(1'b1, ad(IDX_P1_DIR), 8'h0A);
      apb(1'b1, ad(IDX_P0_DIR), 8'h80);
      apb(1'b1, ad(IDX_IRQ_HIGH), {6'h00, m == 2'b11, 1'b0});
      // rate code four: miso needs about ten clocks to come back through the sync
      apb(1'b1, ad(IDX_CONTROL), {4'b1101, m, 2'b00});
      pgo(8'hA5 ^ {6'h00, m});
      apb(1'b1, ad(IDX_DATA), 8'h3C);
      apb(1'b1, ad(IDX_DATA), 8'hFF);
      wait_end;
      chk("status", 32'hC0, rd);
      chk("irq", {31'h0, m == 2'b11}, {31'h0, port_irq});
      rchk("rx", IDX_DATA, 8'hA5 ^ {6'h00, m});
      chk("peer_rx", 32'h3C, {24'h0, p_rx});
      rchk("status_clr", IDX_STATUS, 8'h00);
      chk("irq_clr", 32'h0, {31'h0, port_irq});
      $display("master mode %0d done", m);
   endtask
   task automatic t_slave(input logic h);
      apb(1'b1, ad(IDX_P1_DIR), 8'h04);
      apb(1'b1, ad(IDX_P0_DIR), 8'h00);
      apb(1'b1, ad(IDX_CONTROL), {4'b0100, h, h, 2'b00});
      p_mst <= 1'b1;
      p_pol <= h;
      p_pha <= h;
      apb(1'b1, ad(IDX_DATA), 8'h96);
      repeat (8) @(posedge clock);
      pgo(8'h69);
      wait_end;
      chk("status", 32'h80, rd);
      rchk("rx", IDX_DATA, 8'h69);
      chk("peer_rx", 32'h96, {24'h0, p_rx});
      $display("slave phase %0d done", h);
   endtask
   task automatic t_fault;
      pgo(8'h11);
      repeat (30) @(posedge clock);
      p_rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      p_rst_n <= 1'b1;
      repeat (12) @(posedge clock);
      rchk("fault", IDX_STATUS, 8'h10);
      chk("irq_fault", 32'h1, {31'h0, port_irq});
      rchk("data", IDX_DATA, 8'h69);
      rchk("fault_clr", IDX_STATUS, 8'h00);
      apb(1'b1, ad(IDX_CONTROL), 8'h12);
      p_mst <= 1'b0;
      apb(1'b1, ad(IDX_DATA), 8'h55);
      repeat (150) @(posedge clock);
      rchk("off", IDX_STATUS, 8'h00);
      $display("fault and disable test done");
   endtask
   task automatic t_reset;
      repeat (4) @(posedge clock);
      rchk("control", IDX_CONTROL, CTL_RST);
      rchk("status", IDX_STATUS, 8'h00);
      rchk("irq_low", IDX_IRQ_LOW, 8'h00);
      apb(1'b0, 12'hC00, 8'h00);
      chk("unmapped", 32'h1, {31'h0, err});
      $display("reset test done");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      #2000000;
      err_count++;
      test_done;
   end
   initial begin
      {rst_n, p_rst_n, psel, penable, pwrite, p_start, p_mst, p_pol, p_pha} <= '0;
      {paddr, pwdata, p_tx} <= '0;
      repeat (6) @(posedge clock);
      rst_n   <= 1'b1;
      p_rst_n <= 1'b1;
      t_reset;
      apb(1'b1, ad(IDX_IRQ_LOW), 8'h80);
      for (int m = 0; m < 4; m++) t_master(2'(m));
      t_slave(1'b1);
      t_slave(1'b0);
      t_fault;
      test_done;
   end
endmodule
`default_nettype wire
